// ---- design/iols_cvt_if.sv ----
// Purpose: carries a bitmap to the float converter and the float back
// Assumes: purely combinational path
// Notes: none
`timescale 1ns/1ps
interface iols_cvt_if;
	logic [15:0] bits;
	logic [31:0] flt;
	modport requester (output bits, input flt);
	modport converter (input bits, output flt);
endinterface

// ---- design/iols_pkg.sv ----
// Purpose: shared constants for the level and i/o status register bank
// Assumes: 16-bit holding registers addressed by register index
// Notes: 32-bit values take two registers, high word at the lower index
package iols_pkg;
	// ======================================================
	// sizes
	localparam int NUM_BLOCKS = 8;
	localparam int NUM_INPUTS = 4;
	localparam int NUM_SIGNALS = 32;
	localparam int NUM_AOUT = 4;
	localparam int NUM_LEVELS = 32;
	localparam int NUM_DIG = 48;
	localparam int NUM_BMAP = 8;
	localparam int ADDR_W = 8;
	// ======================================================
	// register index map
	localparam logic [7:0] REG_BRIDGE_BASE = 8'h00;
	localparam logic [7:0] REG_BRIDGE_LAST = 8'h3f;
	localparam logic [7:0] REG_AOUT_BASE = 8'h40;
	localparam logic [7:0] REG_AOUT_LAST = 8'h4b;
	localparam logic [7:0] REG_BMAP_BASE = 8'h50;
	localparam logic [7:0] REG_BMAP_LAST = 8'h57;
	localparam logic [7:0] REG_FLT_BASE = 8'h60;
	localparam logic [7:0] REG_FLT_LAST = 8'h6f;
	// bitmap slots within the bitmap range
	localparam logic [2:0] BMAP_DIN_ONE = 3'h0;
	localparam logic [2:0] BMAP_DIN_TWO = 3'h1;
	localparam logic [2:0] BMAP_DIN_THREE = 3'h2;
	localparam logic [2:0] BMAP_DOUT_ONE = 3'h3;
	localparam logic [2:0] BMAP_DOUT_TWO = 3'h4;
	localparam logic [2:0] BMAP_DOUT_THREE = 3'h5;
	localparam logic [2:0] BMAP_LVL_LOW = 3'h6;
	localparam logic [2:0] BMAP_LVL_HIGH = 3'h7;
	// ======================================================
	// analog output scaled format
	localparam logic [15:0] AOUT_DECIMALS = 16'h0003;
	localparam logic signed [32:0] AOUT_ROUND_HALF = 33'sh0_0000_0005;
	localparam logic signed [32:0] AOUT_ROUND_DIV = 33'sh0_0000_000a;
	// ======================================================
	// float conversion
	localparam logic [7:0] FLT_BIAS = 8'h7f;
	// ======================================================
	// reset values and answer codes
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	localparam logic [1:0] EXC_NONE = 2'h0;
	localparam logic [1:0] EXC_ADDR = 2'h1;
	localparam logic [1:0] EXC_READ_ONLY = 2'h2;
endpackage

// ---- design/iols_status_bank.sv ----
// Purpose: read-only holding register bank of signals, outputs and level flags
// Assumes: digital inputs are pins; all other inputs are on clk_i
// Notes: one read or write taken per req_i, answered one cycle later
`timescale 1ns/1ps
module iols_status_bank
	import iols_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] bridge_sig_i [NUM_SIGNALS],
	input wire logic [NUM_SIGNALS-1:0] input_used_i,
	input wire logic signed [31:0] aout_e4_i [NUM_AOUT],
	input wire logic [NUM_DIG-1:0] din_pin_i,
	input wire logic [NUM_DIG-1:0] dout_state_i,
	input wire logic signed [31:0] supervised_i,
	input wire logic signed [31:0] level_val_i [NUM_LEVELS],
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic ack_o,
	output logic [15:0] rdata_o,
	output logic [1:0] exc_o
);
	// ======================================================
	// state
	logic [NUM_DIG-1:0] din_meta_reg;
	logic [NUM_DIG-1:0] din_sync_reg;
	logic [NUM_DIG-1:0] din_sync_next;
	logic [NUM_DIG-1:0] dout_reg;
	logic [NUM_DIG-1:0] dout_next;
	logic [NUM_LEVELS-1:0] above_reg;
	logic [NUM_LEVELS-1:0] above_next;
	logic signed [31:0] aout_reg [NUM_AOUT];
	logic signed [31:0] aout_next [NUM_AOUT];
	logic ack_reg;
	logic ack_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [1:0] exc_reg;
	logic [1:0] exc_next;

	logic [15:0] bmap [NUM_BMAP];
	logic [15:0] wdata_unused;
	iols_cvt_if cvt_bus();

	assign wdata_unused = wdata_i;

	iols_u16_to_float u_cvt (
		.cvt(cvt_bus.converter)
	);

	// ======================================================
	// level comparators
	genvar g;
	generate
		for (g = 0; g < NUM_LEVELS; g++) begin : g_lvl
			assign above_next[g] = supervised_i > level_val_i[g];
		end
	endgenerate

	// ======================================================
	// analog output rounding to thousandths
	always_comb begin
		logic signed [32:0] biased;
		biased = 33'sh0_0000_0000;
		for (int k = 0; k < NUM_AOUT; k++) begin
			if (aout_e4_i[k] < 0) begin
				biased = {aout_e4_i[k][31], aout_e4_i[k]} - AOUT_ROUND_HALF;
			end else begin
				biased = {aout_e4_i[k][31], aout_e4_i[k]} + AOUT_ROUND_HALF;
			end
			aout_next[k] = 32'(biased / AOUT_ROUND_DIV);
		end
	end

	// ======================================================
	// digital mirrors
	always_comb begin
		din_sync_next = din_meta_reg;
		dout_next = dout_state_i;
	end

	assign bmap[BMAP_DIN_ONE] = din_sync_reg[15:0];
	assign bmap[BMAP_DIN_TWO] = din_sync_reg[31:16];
	assign bmap[BMAP_DIN_THREE] = din_sync_reg[47:32];
	assign bmap[BMAP_DOUT_ONE] = dout_reg[15:0];
	assign bmap[BMAP_DOUT_TWO] = dout_reg[31:16];
	assign bmap[BMAP_DOUT_THREE] = dout_reg[47:32];
	assign bmap[BMAP_LVL_LOW] = above_reg[15:0];
	assign bmap[BMAP_LVL_HIGH] = above_reg[31:16];

	// ======================================================
	// register read decode
	always_comb begin
		logic [7:0] off;
		logic [4:0] sidx;
		logic [31:0] sval;
		logic [1:0] aidx;
		logic [1:0] apart;
		off = 8'h00;
		sidx = 5'h00;
		sval = 32'h0000_0000;
		aidx = 2'h0;
		apart = 2'h0;
		cvt_bus.bits = 16'h0000;
		ack_next = req_i;
		rdata_next = RDATA_RESET;
		exc_next = EXC_NONE;
		if (req_i) begin
			if (addr_i <= REG_BRIDGE_LAST) begin
				sidx = addr_i[5:1];
				sval = input_used_i[sidx] ? bridge_sig_i[sidx] : 32'h0000_0000;
				rdata_next = addr_i[0] ? sval[15:0] : sval[31:16];
			end else if (addr_i >= REG_AOUT_BASE && addr_i <= REG_AOUT_LAST) begin
				off = addr_i - REG_AOUT_BASE;
				aidx = 2'(off / 8'h03);
				apart = 2'(off % 8'h03);
				case (apart)
					2'h0: begin
						rdata_next = aout_reg[aidx][31:16];
					end
					2'h1: begin
						rdata_next = aout_reg[aidx][15:0];
					end
					default: begin
						rdata_next = AOUT_DECIMALS;
					end
				endcase
			end else if (addr_i >= REG_BMAP_BASE && addr_i <= REG_BMAP_LAST) begin
				off = addr_i - REG_BMAP_BASE;
				rdata_next = bmap[off[2:0]];
			end else if (addr_i >= REG_FLT_BASE && addr_i <= REG_FLT_LAST) begin
				off = addr_i - REG_FLT_BASE;
				// bitmap as float, high word first
				cvt_bus.bits = bmap[off[3:1]];
				rdata_next = off[0] ? cvt_bus.flt[15:0] : cvt_bus.flt[31:16];
			end else begin
				exc_next = EXC_ADDR;
			end
			if (we_i) begin
				rdata_next = RDATA_RESET;
				if (exc_next == EXC_NONE) begin
					exc_next = EXC_READ_ONLY;
				end
			end
		end
	end

	// ======================================================
	// registers
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			din_meta_reg <= '0;
			din_sync_reg <= '0;
			dout_reg <= '0;
			above_reg <= '0;
			for (int k = 0; k < NUM_AOUT; k++) begin
				aout_reg[k] <= 32'sh0000_0000;
			end
			ack_reg <= 1'b0;
			rdata_reg <= RDATA_RESET;
			exc_reg <= EXC_NONE;
		end else begin
			din_meta_reg <= din_pin_i;
			din_sync_reg <= din_sync_next;
			dout_reg <= dout_next;
			above_reg <= above_next;
			for (int k = 0; k < NUM_AOUT; k++) begin
				aout_reg[k] <= aout_next[k];
			end
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			exc_reg <= exc_next;
		end
	end

	assign ack_o = ack_reg;
	assign rdata_o = rdata_reg;
	assign exc_o = exc_reg;
endmodule

// ---- design/iols_u16_to_float.sv ----
// Purpose: unsigned 16-bit bitmap to single precision float
// Assumes: exact, every 16-bit value fits the mantissa
// Notes: zero gives all-zero float
`timescale 1ns/1ps
module iols_u16_to_float
	import iols_pkg::*;
(
	iols_cvt_if.converter cvt
);
	logic [3:0] msb;
	logic [31:0] shifted;
	logic [7:0] expo;

	// ======================================================
	// leading one, then normalise
	always_comb begin
		msb = 4'h0;
		for (int b = 0; b < 16; b++) begin
			if (cvt.bits[b]) begin
				msb = 4'(b);
			end
		end
		shifted = {cvt.bits, 16'h0000} << (4'hf - msb);
		expo = FLT_BIAS + {4'h0, msb};
		if (cvt.bits == 16'h0000) begin
			cvt.flt = 32'h0000_0000;
		end else begin
			cvt.flt = {1'b0, expo, shifted[30:8]};
		end
	end
endmodule

// ---- tb/iols_master_model.sv ----
// Purpose: register-access master facing the status bank
// Assumes: one request per call, answer one cycle later
// Notes: released qualifiers show junk, not the last value
`timescale 1ns/1ps
module iols_master_model
	import iols_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic [1:0] exc_i,
	output logic req_o,
	output logic we_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [15:0] wdata_o
);
	initial begin
		req_o = 1'b0;
		{we_o, addr_o, wdata_o} = '0;
	end
	task automatic access(input logic w, input logic [7:0] a, output logic [15:0] d,
		output logic [1:0] e);
		@(negedge clk_i);
		{req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, 16'ha5a5};
		@(negedge clk_i);
		{req_o, we_o, addr_o, wdata_o} = {1'b0, ~w, ~a, 16'h5a5a};
		d = rdata_i;
		e = exc_i;
	endtask
	task automatic read_pair(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		access(1'b0, {a[7:1], 1'b0}, v[31:16], e);
		access(1'b0, {a[7:1], 1'b1}, v[15:0], e);
	endtask
endmodule

// ---- tb/iols_status_bank_properties.sv ----
// Purpose: answer port checks for the status bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to iols_status_bank
`timescale 1ns/1ps
module iols_status_bank_properties
	import iols_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [NUM_DIG-1:0] din_pin_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic ack_o,
	input wire logic [15:0] rdata_o,
	input wire logic [1:0] exc_o
);
	logic [NUM_DIG-1:0] din_q;
	logic [3:0] calm;
	wire logic hit = addr_i <= REG_AOUT_LAST ||
		addr_i inside {[REG_BMAP_BASE:REG_BMAP_LAST], [REG_FLT_BASE:REG_FLT_LAST]};
	// ======================================================
	// cycles since the pins last moved
	always_ff @(posedge clk_i) begin
		din_q <= din_pin_i;
		calm <= (!resetn_i || din_pin_i != din_q) ? 4'h0 : calm + {3'h0, calm != 4'hf};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd;
		req_i && !we_i;
	endsequence
	a_ack_one_cycle: assert property (req_i |=> ack_o) else $error("request not answered");
	a_idle_quiet: assert property (!req_i |=> !ack_o && rdata_o == 16'h0 && exc_o == EXC_NONE)
		else $error("answer without request");
	a_write_refused: assert property (req_i && we_i && hit |=>
		exc_o == EXC_READ_ONLY && rdata_o == 16'h0) else $error("write not refused");
	a_unmapped_addr: assert property (req_i && !hit |=> exc_o == EXC_ADDR && rdata_o == 16'h0)
		else $error("unmapped index not refused");
	a_read_ok: assert property (s_rd ##0 hit |=> exc_o == EXC_NONE) else $error("read refused");
	a_aout_decimals: assert property (s_rd ##0 addr_i inside {8'h42, 8'h45, 8'h48, 8'h4b} |=>
		rdata_o == AOUT_DECIMALS) else $error("decimal count wrong");
	a_din_bank_one: assert property (s_rd ##0 (addr_i == 8'h50 && calm > 4'h3) |=>
		rdata_o == $past(din_pin_i[15:0])) else $error("input bitmap one wrong");
	a_din_bank_two: assert property (s_rd ##0 (addr_i == 8'h51 && calm > 4'h3) |=>
		rdata_o == $past(din_pin_i[31:16])) else $error("input bitmap two wrong");
endmodule
bind iols_status_bank iols_status_bank_properties u_props (.clk_i, .resetn_i, .din_pin_i,
	.req_i, .we_i, .addr_i, .ack_o, .rdata_o, .exc_o);

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the status bank
// Assumes: inputs change at the falling edge
// Notes: expected bitmaps rebuilt from the inputs each pass
`timescale 1ns/1ps
module testbench
	import iols_pkg::*;
;
	logic clk_i, resetn_i, req_i, we_i, ack_o;
	logic [31:0] bridge_sig_i [NUM_SIGNALS];
	logic [31:0] input_used_i;
	logic signed [31:0] aout_e4_i [NUM_AOUT];
	logic signed [31:0] level_val_i [NUM_LEVELS];
	logic signed [31:0] supervised_i;
	logic [NUM_DIG-1:0] din_pin_i, dout_state_i;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o, d;
	logic [1:0] exc_o, e;
	logic [31:0] v, lvl;
	logic [15:0] bm [NUM_BMAP];
	// unmapped indices: gaps between ranges and the top of the map
	logic [7:0] bad_addr [NUM_BMAP] = '{8'h4c, 8'h4f, 8'h58, 8'h5f, 8'h70, 8'h9b, 8'hc6, 8'hff};
	int error_cnt, compares, cyc;
	iols_status_bank DUT (.clk_i, .resetn_i, .bridge_sig_i, .input_used_i, .aout_e4_i,
		.din_pin_i, .dout_state_i, .supervised_i, .level_val_i, .req_i, .we_i, .addr_i,
		.wdata_i, .ack_o, .rdata_o, .exc_o);
	iols_master_model M (.clk_i, .rdata_i(rdata_o), .exc_i(exc_o), .req_o(req_i), .we_o(we_i),
		.addr_o(addr_i), .wdata_o(wdata_i));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	function automatic logic [31:0] to_flt(input logic [15:0] n);
		int p = 15;
		if (n == 16'h0) return 32'h0;
		while (!n[p]) p--;
		return {1'b0, 8'(127 + p), 23'({n, 23'h0} >> p)};
	endfunction
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (++cyc == 3000) begin
		error_cnt++;
		finish_test();
	end
	initial begin
		{resetn_i, input_used_i, din_pin_i, dout_state_i} = {1'b0, 32'h96a5_0ff1,
			48'h8001_7e3c_0011, 48'h1248_ffff_c003};
		supervised_i = 32'sd100;
		for (int i = 0; i < NUM_SIGNALS; i++) bridge_sig_i[i] = 32'h40a0_0100 + i;
		for (int i = 0; i < NUM_LEVELS; i++) level_val_i[i] = (i % 3 == 0) ? 100 : i * 9 - 120;
		for (int k = 0; k < NUM_AOUT; k++) aout_e4_i[k] = k[0] ? -13345 - k : 12345 + k * 6;
		repeat (12) @(negedge clk_i);
		resetn_i = 1'b1;
		for (int s = 0; s < NUM_SIGNALS; s++) begin
			M.read_pair(8'(2 * s), v, e);
			check("bridge", v, input_used_i[s] ? bridge_sig_i[s] : 32'h0);
			check("bridge exc", e, EXC_NONE);
		end
		for (int k = 0; k < NUM_AOUT; k++) begin
			M.access(1'b0, 8'(64 + 3 * k), d, e);
			v[31:16] = d;
			M.access(1'b0, 8'(65 + 3 * k), d, e);
			check("aout", {v[31:16], d}, k[0] ? (aout_e4_i[k] - 5) / 10 : (aout_e4_i[k] + 5) / 10);
			M.access(1'b0, 8'(66 + 3 * k), d, e);
			check("decimals", d, 32'h3);
		end
		for (int pass = 0; pass < 2; pass++) begin
			repeat (5) @(negedge clk_i);
			for (int i = 0; i < NUM_LEVELS; i++) lvl[i] = supervised_i > level_val_i[i];
			{bm[2], bm[1], bm[0], bm[5], bm[4], bm[3]} = {din_pin_i, dout_state_i};
			{bm[7], bm[6]} = lvl;
			for (int k = 0; k < NUM_BMAP; k++) begin
				M.access(1'b0, 8'(80 + k), d, e);
				check("bitmap", d, bm[k]);
				M.read_pair(8'(96 + 2 * k), v, e);
				check("float", v, to_flt(bm[k]));
			end
			M.access(1'b1, 8'h50, d, e);
			check("write exc", e, EXC_READ_ONLY);
			check("write ack", {ack_o, d}, {1'b1, 16'h0});
			M.access(1'b0, 8'h50, d, e);
			check("after write", d, bm[0]);
			{din_pin_i, dout_state_i} = {~din_pin_i, ~dout_state_i};
			supervised_i = 32'sd0;
		end
		foreach (bm[k]) begin
			M.access(k[0], bad_addr[k], d, e);
			check("unmapped", {d, e}, {16'h0, EXC_ADDR});
		end
		finish_test();
	end
endmodule
